// [ninth_bit_and_wait_control.sv]
`include "ninth_bit_consts.svh"

module ninth_bit_and_wait_control (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic [7:0] serial0_control_reg,
	input wire logic serial_channel_zero_busy,
	input wire logic serial_byte_req,
	input wire logic clock_stopped_idle,
	input wire logic deep_standby_mode,
	input wire ninth_bit_pkg::req_type instr_req,
	output ninth_bit_pkg::res_type result_q,
	output logic ninth_bit_carry_flag_q,
	output logic cpu_stall_q,
	output logic ram_xfer_q,
	output logic periph_run_q
);

	////////////////////////////////////////////////////////////////////////
	// Datapath function

	function automatic ninth_bit_pkg::res_type execute(
		input ninth_bit_pkg::req_type rq,
		input logic flag);
		ninth_bit_pkg::res_type r;
		logic lo_n;
		logic hi_n;
		logic [8:0] v9;
		logic [16:0] v17;
		r = '0;
		// Plain registers have no ninth bit storage
		lo_n = rq.lo_plain ? `PLAIN_NINTH : rq.lo.ninth;
		hi_n = rq.hi_plain ? `PLAIN_NINTH : rq.hi.ninth;
		v9 = '0;
		v17 = '0;
		r.valid = rq.valid;
		r.lo = rq.lo;
		r.hi = rq.hi;
		r.flag = flag;
		case (rq.op)
			ninth_bit_pkg::load_byte: begin
				r.flag_we = 1'b1;
				r.flag = lo_n;
			end
			ninth_bit_pkg::load_word: begin
				r.flag_we = 1'b1;
				r.flag = hi_n;
			end
			ninth_bit_pkg::store_byte, ninth_bit_pkg::move_byte: begin
				r.wr_lo = 1'b1;
				r.lo.ninth = flag;
			end
			ninth_bit_pkg::store_word: begin
				r.wr_lo = 1'b1;
				r.wr_hi = 1'b1;
				r.lo.ninth = flag;
				r.hi.ninth = flag;
			end
			ninth_bit_pkg::stack_save_imm, ninth_bit_pkg::stack_save_psw: begin
				r.wr_lo = 1'b1;
				r.lo.ninth = flag;
			end
			ninth_bit_pkg::stack_save_pair: begin
				r.wr_lo = 1'b1;
				r.wr_hi = 1'b1;
				r.lo.ninth = flag;
				r.hi.ninth = flag;
			end
			ninth_bit_pkg::stack_save_byte: begin
				r.wr_lo = 1'b1;
				r.lo.ninth = lo_n;
				r.flag_we = 1'b1;
				r.flag = lo_n;
			end
			ninth_bit_pkg::stack_save_word: begin
				r.wr_lo = 1'b1;
				r.wr_hi = 1'b1;
				r.lo.ninth = lo_n;
				r.hi.ninth = hi_n;
				r.flag_we = 1'b1;
				r.flag = hi_n;
			end
			ninth_bit_pkg::stack_restore_byte: begin
				r.wr_lo = 1'b1;
				r.lo.ninth = lo_n;
				r.flag_we = 1'b1;
				r.flag = rq.to_psw ? rq.lo.data[`PSW_FLAG_BIT] : lo_n;
			end
			ninth_bit_pkg::stack_restore_word: begin
				r.wr_lo = 1'b1;
				r.wr_hi = 1'b1;
				r.lo.ninth = lo_n;
				r.hi.ninth = hi_n;
				r.flag_we = 1'b1;
				r.flag = rq.to_psw ? rq.hi.data[`PSW_FLAG_BIT] : hi_n;
			end
			ninth_bit_pkg::stack_restore_psw: begin
				// Stacked ninth bit is ignored here
				r.flag_we = 1'b1;
				r.flag = rq.lo.data[`PSW_FLAG_BIT];
			end
			ninth_bit_pkg::stack_restore_pair: begin
				r.flag_we = 1'b1;
				r.flag = hi_n;
			end
			ninth_bit_pkg::add_one_byte: begin
				v9 = {lo_n, rq.lo.data} + `STEP9;
				r.wr_lo = 1'b1;
				r.lo = v9;
				r.flag_we = 1'b1;
				r.flag = v9[8];
			end
			ninth_bit_pkg::sub_one_byte, ninth_bit_pkg::count_down_branch_zero,
			ninth_bit_pkg::count_down_branch_nonzero: begin
				v9 = {lo_n, rq.lo.data} - `STEP9;
				r.wr_lo = 1'b1;
				r.lo = v9;
				r.flag_we = 1'b1;
				r.flag = v9[8];
				// Branch test ignores the ninth bit
				if (rq.op == ninth_bit_pkg::count_down_branch_zero) begin
					r.branch = (v9[7:0] == `BYTE_ZERO);
				end else if (rq.op == ninth_bit_pkg::count_down_branch_nonzero) begin
					r.branch = (v9[7:0] != `BYTE_ZERO);
				end
			end
			ninth_bit_pkg::add_one_word: begin
				v17 = {hi_n, rq.hi.data, rq.lo.data} + `STEP17;
				r.wr_lo = 1'b1;
				r.wr_hi = 1'b1;
				r.lo.data = v17[7:0];
				r.lo.ninth = (rq.lo.data == `BYTE_ALL_ONES);
				r.hi = v17[16:8];
				r.flag_we = 1'b1;
				r.flag = v17[16];
			end
			ninth_bit_pkg::sub_one_word: begin
				v17 = {hi_n, rq.hi.data, rq.lo.data} - `STEP17;
				r.wr_lo = 1'b1;
				r.wr_hi = 1'b1;
				r.lo.data = v17[7:0];
				r.lo.ninth = ~(rq.lo.data == `BYTE_ZERO);
				r.hi = v17[16:8];
				r.flag_we = 1'b1;
				r.flag = v17[16];
			end
			ninth_bit_pkg::multiply_24bit, ninth_bit_pkg::divide_24bit: begin
				r.wr_lo = 1'b1;
				r.wr_hi = 1'b1;
				r.lo.ninth = 1'b1;
				r.hi.ninth = 1'b1;
			end
			default: begin
				r.valid = rq.valid;
			end
		endcase
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Wait insertion

	logic pend_q;
	logic pend_d;
	logic wait_d;
	logic low_power;
	logic new_req;
	logic accept;
	ninth_bit_pkg::res_type res_d;
	logic flag_d;

	assign low_power = clock_stopped_idle | deep_standby_mode;
	assign new_req = serial_byte_req & serial_channel_zero_busy
		& serial0_control_reg[`CONT_XFER_BIT];
	// A request landing during a wait is held and served later, unless low power clears it
	assign wait_d = (pend_q | new_req) & ~cpu_stall_q & ~low_power;
	// A request served at once must not stay pending, or it would raise a second wait
	assign pend_d = ~low_power & ((pend_q & (~wait_d | new_req)) | (new_req & ~wait_d));
	// Instructions wait while stalled; the caller keeps the request steady
	assign accept = instr_req.valid & ~cpu_stall_q;
	assign res_d = execute(instr_req, ninth_bit_carry_flag_q);
	assign flag_d = (accept & res_d.flag_we) ? res_d.flag : ninth_bit_carry_flag_q;

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			pend_q <= 1'b0;
			cpu_stall_q <= `WAIT_RESET;
			ram_xfer_q <= `WAIT_RESET;
			periph_run_q <= `PERIPH_RUN_RESET;
		end else begin
			pend_q <= pend_d;
			cpu_stall_q <= wait_d;
			ram_xfer_q <= wait_d;
			// Peripheral run ignores the stall on purpose
			periph_run_q <= ~low_power;
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			result_q <= '0;
			ninth_bit_carry_flag_q <= `FLAG_RESET;
		end else begin
			result_q <= accept ? res_d : '0;
			ninth_bit_carry_flag_q <= flag_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rstn);

	a_wait_not_twice: assert property (cpu_stall_q |=> !cpu_stall_q)
		else $error("wait cycles back to back");
	a_wait_from_req: assert property (new_req && !cpu_stall_q && !low_power
		|=> cpu_stall_q && ram_xfer_q)
		else $error("serial request gave no wait");
	a_wait_low_power: assert property (low_power |=> !cpu_stall_q)
		else $error("wait during low power");
	a_stall_blocks_exec: assert property (cpu_stall_q |=> !result_q.valid)
		else $error("instruction ran during wait");
	a_periph_keeps_run: assert property (cpu_stall_q && !low_power |-> periph_run_q)
		else $error("peripherals stopped in wait");
	a_load_byte_flag: assert property (accept && instr_req.op == ninth_bit_pkg::load_byte
		&& !instr_req.lo_plain |=> ninth_bit_carry_flag_q == $past(instr_req.lo.ninth))
		else $error("byte load flag wrong");
	a_store_word_ninth: assert property (accept && instr_req.op == ninth_bit_pkg::store_word
		|=> result_q.lo.ninth == $past(ninth_bit_carry_flag_q)
		&& result_q.hi.ninth == $past(ninth_bit_carry_flag_q))
		else $error("word store ninth bits wrong");
	a_save_word_flag: assert property (accept && instr_req.op == ninth_bit_pkg::stack_save_word
		&& !instr_req.hi_plain |=> ninth_bit_carry_flag_q == $past(instr_req.hi.ninth))
		else $error("word save flag wrong");
	a_restore_psw_flag: assert property (accept && instr_req.op == ninth_bit_pkg::stack_restore_psw
		|=> ninth_bit_carry_flag_q == $past(instr_req.lo.data[`PSW_FLAG_BIT]))
		else $error("status restore flag wrong");
	a_branch_low_bits: assert property (accept
		&& instr_req.op == ninth_bit_pkg::count_down_branch_zero
		&& instr_req.lo.data == 8'h01 |=> result_q.branch)
		else $error("count down branch missed");
	a_dec_word_borrow: assert property (accept && instr_req.op == ninth_bit_pkg::sub_one_word
		&& instr_req.lo.data == 8'h00 |=> !result_q.lo.ninth && result_q.lo.data == 8'hff)
		else $error("word decrement borrow wrong");
	a_mul_keeps_flag: assert property (accept && instr_req.op == ninth_bit_pkg::multiply_24bit
		|=> result_q.lo.ninth && result_q.hi.ninth && $stable(ninth_bit_carry_flag_q))
		else $error("multiply ninth or flag wrong");
	a_plain_reads_one: assert property (accept && instr_req.op == ninth_bit_pkg::load_byte
		&& instr_req.lo_plain |=> ninth_bit_carry_flag_q)
		else $error("plain register ninth not one");
	a_xfer_with_stall: assert property (ram_xfer_q == cpu_stall_q)
		else $error("transfer strobe apart from wait");
	a_wait_served: assert property (pend_q && !cpu_stall_q && !low_power
		|=> cpu_stall_q)
		else $error("pending request not served");
	a_store_byte_ninth: assert property (accept && instr_req.op == ninth_bit_pkg::store_byte
		|=> result_q.wr_lo && result_q.lo.ninth == $past(ninth_bit_carry_flag_q))
		else $error("byte store ninth bit wrong");
	a_load_word_flag: assert property (accept && instr_req.op == ninth_bit_pkg::load_word
		&& !instr_req.hi_plain |=> ninth_bit_carry_flag_q == $past(instr_req.hi.ninth))
		else $error("word load flag wrong");
	a_save_imm_ninth: assert property (accept && instr_req.op == ninth_bit_pkg::stack_save_imm
		|=> result_q.lo.ninth == $past(ninth_bit_carry_flag_q))
		else $error("immediate save ninth bit wrong");
	a_restore_byte_flag: assert property (accept
		&& instr_req.op == ninth_bit_pkg::stack_restore_byte && !instr_req.to_psw
		&& !instr_req.lo_plain |=> ninth_bit_carry_flag_q == $past(instr_req.lo.ninth))
		else $error("byte restore flag wrong");
	a_inc_byte_carry: assert property (accept && instr_req.op == ninth_bit_pkg::add_one_byte
		&& !instr_req.lo_plain && !instr_req.lo.ninth && instr_req.lo.data == 8'hff
		|=> ninth_bit_carry_flag_q && result_q.lo == 9'h100)
		else $error("byte increment carry wrong");
	a_dec_word_high: assert property (accept && instr_req.op == ninth_bit_pkg::sub_one_word
		&& !instr_req.hi_plain && instr_req.hi == 9'h100 && instr_req.lo.data == 8'h00
		|=> !ninth_bit_carry_flag_q && result_q.hi == 9'h0ff)
		else $error("word decrement high byte wrong");
	a_div_ninth_one: assert property (accept && instr_req.op == ninth_bit_pkg::divide_24bit
		|=> result_q.lo.ninth && result_q.hi.ninth && $stable(ninth_bit_carry_flag_q))
		else $error("divide ninth or flag wrong");
	a_plain_hi_one: assert property (accept && instr_req.op == ninth_bit_pkg::load_word
		&& instr_req.hi_plain |=> ninth_bit_carry_flag_q)
		else $error("plain high register ninth not one");

	c_wait_seen: cover property (new_req ##1 cpu_stall_q ##1 !cpu_stall_q);
	c_req_in_wait: cover property (cpu_stall_q && new_req ##2 cpu_stall_q);
	c_add_one_word_carry: cover property (accept && instr_req.op == ninth_bit_pkg::add_one_word
		&& instr_req.lo.data == 8'hff);
	c_branch_taken: cover property (result_q.branch);
	c_pending_served: cover property (pend_q && !cpu_stall_q ##1 cpu_stall_q);

endmodule

// [ninth_bit_consts.svh]
`ifndef NINTH_BIT_CONSTS_SVH
`define NINTH_BIT_CONSTS_SVH

// Serial control bit that enables continuous transfer
`define CONT_XFER_BIT 4
// Position of the carry flag inside the status word
`define PSW_FLAG_BIT 1
// Ninth bit seen on a register that has none
`define PLAIN_NINTH 1'b1
// Reset values
`define FLAG_RESET 1'b0
`define WAIT_RESET 1'b0
`define PERIPH_RUN_RESET 1'b0
// Increment and decrement steps
`define STEP9 9'h001
`define STEP17 17'h00001
// Byte values that produce a carry or borrow out of the low byte
`define BYTE_ALL_ONES 8'hff
`define BYTE_ZERO 8'h00

`endif

// [ninth_bit_pkg.sv]
package ninth_bit_pkg;

	typedef enum logic [4:0] {
		op_none,
		load_byte,
		load_word,
		store_byte,
		store_word,
		move_byte,
		stack_save_imm,
		stack_save_byte,
		stack_save_word,
		stack_save_psw,
		stack_save_pair,
		stack_restore_byte,
		stack_restore_word,
		stack_restore_psw,
		stack_restore_pair,
		add_one_byte,
		sub_one_byte,
		count_down_branch_zero,
		count_down_branch_nonzero,
		add_one_word,
		sub_one_word,
		multiply_24bit,
		divide_24bit
	} op_type;

	typedef struct packed {
		logic ninth;
		logic [7:0] data;
	} loc9_type;

	typedef struct packed {
		logic valid;
		op_type op;
		loc9_type lo;
		loc9_type hi;
		logic lo_plain;
		logic hi_plain;
		logic to_psw;
	} req_type;

	typedef struct packed {
		logic valid;
		logic wr_lo;
		logic wr_hi;
		loc9_type lo;
		loc9_type hi;
		logic flag_we;
		logic flag;
		logic branch;
	} res_type;

endpackage

// [loc_store.sv]
module loc_store (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire ninth_bit_pkg::res_type result_q,
	output ninth_bit_pkg::loc9_type lo_q,
	output ninth_bit_pkg::loc9_type hi_q
);
	timeunit 1ns;
	timeprecision 1ps;
	// Cleared on reset only so a stale write stays visible to the bench
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			lo_q <= '0;
			hi_q <= '0;
		end else if (result_q.valid) begin
			if (result_q.wr_lo) lo_q <= result_q.lo;
			if (result_q.wr_hi) hi_q <= result_q.hi;
		end
	end
endmodule

// [tb.sv]
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {
		ninth_bit_pkg::op_type op;
		logic [17:0] opnd;
		logic [2:0] mode;
		logic [17:0] exp;
		logic chk;
		logic flag;
		logic br;
	} row_type;
	logic ref_clk = 0, rstn = 0, busy = 1, sreq = 0, idle = 0, stby = 0;
	logic [7:0] ctrl = 8'h10;
	ninth_bit_pkg::req_type instr_req = '0;
	ninth_bit_pkg::res_type result_q;
	ninth_bit_pkg::loc9_type lo_q, hi_q;
	logic flag_q, stall, xfer, run;
	int n_fail = 0, checks = 0;
	// Rows run in order: store rows depend on the flag left by the row above
	row_type rows [29] = '{
		'{ninth_bit_pkg::load_byte, 18'h00155, 3'h0, 18'h00000, 1'h0, 1'h1, 1'h0},
		'{ninth_bit_pkg::store_byte, 18'h000aa, 3'h0, 18'h001aa, 1'h1, 1'h1, 1'h0},
		'{ninth_bit_pkg::load_word, 18'h02500, 3'h0, 18'h00000, 1'h0, 1'h0, 1'h0},
		'{ninth_bit_pkg::store_word, 18'h22534, 3'h0, 18'h02434, 1'h1, 1'h0, 1'h0},
		'{ninth_bit_pkg::move_byte, 18'h00177, 3'h0, 18'h00077, 1'h1, 1'h0, 1'h0},
		'{ninth_bit_pkg::stack_save_byte, 18'h00120, 3'h0, 18'h00120, 1'h1, 1'h1, 1'h0},
		'{ninth_bit_pkg::stack_save_imm, 18'h00005, 3'h0, 18'h00105, 1'h1, 1'h1, 1'h0},
		'{ninth_bit_pkg::stack_save_word, 18'h00501, 3'h0, 18'h00501, 1'h1, 1'h0, 1'h0},
		'{ninth_bit_pkg::stack_save_pair, 18'h28833, 3'h0, 18'h08833, 1'h1, 1'h0, 1'h0},
		'{ninth_bit_pkg::stack_save_psw, 18'h001ff, 3'h0, 18'h000ff, 1'h1, 1'h0, 1'h0},
		'{ninth_bit_pkg::stack_restore_byte, 18'h00133, 3'h0, 18'h00133, 1'h1, 1'h1, 1'h0},
		'{ninth_bit_pkg::stack_restore_word, 18'h08800, 3'h0, 18'h08800, 1'h1, 1'h0, 1'h0},
		'{ninth_bit_pkg::stack_restore_psw, 18'h00002, 3'h0, 18'h00000, 1'h0, 1'h1, 1'h0},
		'{ninth_bit_pkg::stack_restore_pair, 18'h00000, 3'h0, 18'h00000, 1'h0, 1'h0, 1'h0},
		'{ninth_bit_pkg::stack_restore_byte, 18'h00002, 3'h1, 18'h00000, 1'h0, 1'h1, 1'h0},
		'{ninth_bit_pkg::add_one_byte, 18'h000ff, 3'h0, 18'h00100, 1'h1, 1'h1, 1'h0},
		'{ninth_bit_pkg::sub_one_byte, 18'h00100, 3'h0, 18'h000ff, 1'h1, 1'h0, 1'h0},
		'{ninth_bit_pkg::count_down_branch_zero, 18'h00101, 3'h0, 18'h00100, 1'h1, 1'h1, 1'h1},
		'{ninth_bit_pkg::count_down_branch_nonzero, 18'h00001, 3'h0, 18'h00000, 1'h1, 1'h0, 1'h0},
		'{ninth_bit_pkg::count_down_branch_nonzero, 18'h00100, 3'h0, 18'h000ff, 1'h1, 1'h0, 1'h1},
		'{ninth_bit_pkg::add_one_word, 18'h1feff, 3'h0, 18'h20100, 1'h1, 1'h1, 1'h0},
		'{ninth_bit_pkg::sub_one_word, 18'h20000, 3'h0, 18'h1feff, 1'h1, 1'h0, 1'h0},
		'{ninth_bit_pkg::multiply_24bit, 18'h04411, 3'h0, 18'h24511, 1'h1, 1'h0, 1'h0},
		'{ninth_bit_pkg::load_byte, 18'h00010, 3'h4, 18'h00000, 1'h0, 1'h1, 1'h0},
		'{ninth_bit_pkg::divide_24bit, 18'h00000, 3'h0, 18'h20100, 1'h1, 1'h1, 1'h0},
		'{ninth_bit_pkg::op_none, 18'h0005a, 3'h0, 18'h0005a, 1'h1, 1'h1, 1'h0},
		'{ninth_bit_pkg::add_one_byte, 18'h000ff, 3'h4, 18'h00000, 1'h1, 1'h0, 1'h0},
		'{ninth_bit_pkg::stack_restore_word, 18'h00400, 3'h1, 18'h00400, 1'h1, 1'h1, 1'h0},
		'{ninth_bit_pkg::load_word, 18'h00000, 3'h2, 18'h00000, 1'h0, 1'h1, 1'h0}
	};

	always #5 ref_clk = ~ref_clk;

	ninth_bit_and_wait_control DUT (.ref_clk(ref_clk), .rstn(rstn),
		.serial0_control_reg(ctrl), .serial_channel_zero_busy(busy), .serial_byte_req(sreq),
		.clock_stopped_idle(idle), .deep_standby_mode(stby), .instr_req(instr_req),
		.result_q(result_q), .ninth_bit_carry_flag_q(flag_q), .cpu_stall_q(stall),
		.ram_xfer_q(xfer), .periph_run_q(run));
	loc_store ram (.ref_clk(ref_clk), .rstn(rstn), .result_q(result_q), .lo_q(lo_q), .hi_q(hi_q));

	task automatic cmp(input string what, input logic [17:0] e, input logic [17:0] g);
		checks++;
		if (g !== e) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", what, e, g);
		end
	endtask

	task automatic end_of_test;
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask

	// cond is {busy, standby, idle}; one sample per cycle after the request edge
	task automatic wait_case(input int n, input logic [7:0] ctl, input logic [2:0] cond,
		input logic [3:0] es, input logic [3:0] er);
		logic [3:0] s, x, r;
		@(posedge ref_clk);
		ctrl <= ctl;
		{busy, stby, idle} <= cond;
		sreq <= 1;
		for (int k = 0; k < 4; k++) begin
			@(posedge ref_clk);
			if (k + 1 >= n) sreq <= 0;
			#1;
			s[k] = stall;
			x[k] = xfer;
			r[k] = run;
		end
		cmp("stall", 18'(es), 18'(s));
		cmp("xfer", 18'(es), 18'(x));
		cmp("run", 18'(er), 18'(r));
		$display("wait test done");
	endtask

	initial begin
		#20us;
		n_fail++;
		end_of_test();
	end

	initial begin
		repeat (3) @(posedge ref_clk);
		rstn <= 1;
		#1;
		cmp("reset", 18'h0, 18'(|{result_q, flag_q, stall, xfer}));
		for (int i = 0; i < 29; i++) begin
			@(posedge ref_clk);
			instr_req <= {1'b1, rows[i].op, rows[i].opnd[8:0], rows[i].opnd[17:9], rows[i].mode};
			@(posedge ref_clk);
			instr_req <= '0;
			#1;
			cmp("valid", 18'h1, 18'(result_q.valid));
			cmp("flag", 18'(rows[i].flag), 18'(flag_q));
			if (rows[i].chk) cmp("lo_hi", rows[i].exp, {result_q.hi, result_q.lo});
			cmp("branch", 18'(rows[i].br), 18'(result_q.branch));
		end
		$display("table test done");
		wait_case(1, 8'h10, 3'h4, 4'h1, 4'hf);
		wait_case(2, 8'h10, 3'h4, 4'h5, 4'hf);
		wait_case(1, 8'hef, 3'h4, 4'h0, 4'hf);
		wait_case(1, 8'h10, 3'h0, 4'h0, 4'hf);
		wait_case(1, 8'h10, 3'h5, 4'h0, 4'h0);
		wait_case(1, 8'h10, 3'h6, 4'h0, 4'h0);
		// An instruction that meets a wait cycle must be held, then taken once
		@(posedge ref_clk);
		{busy, stby, idle} <= 3'h4;
		sreq <= 1;
		@(posedge ref_clk);
		sreq <= 0;
		instr_req <= {1'b1, ninth_bit_pkg::load_byte, 9'h100, 9'h000, 3'h0};
		@(posedge ref_clk);
		#1;
		cmp("held", 18'h0, 18'(result_q.valid));
		@(posedge ref_clk);
		instr_req <= '0;
		#1;
		cmp("taken", 18'h1, 18'(result_q.valid & flag_q));
		rstn <= 0;
		#1;
		cmp("mid reset", 18'h0, 18'(|{result_q, flag_q, stall}));
		@(posedge ref_clk);
		rstn <= 1;
		@(posedge ref_clk);
		instr_req <= {1'b1, ninth_bit_pkg::store_word, 9'h134, 9'h112, 3'h0};
		@(posedge ref_clk);
		instr_req <= '0;
		@(posedge ref_clk);
		#1;
		cmp("stored", 18'h02434, {hi_q, lo_q});
		$display("hand test done");
		end_of_test();
	end
endmodule
